// *** design/adc_compute_pkg.sv ***
// Purpose: Shared constants and types for the converter computation block
// Assumes: 8-bit register port, 16-bit signed deviation arithmetic
// Notes:   Offsets are byte addresses on the plain register port
package adc_compute_pkg;

  // ***********************************************
  // Register map
  // ***********************************************
  localparam logic [11:0] ctrl3_offset  = 12'h114;
  localparam logic [11:0] status_offset = 12'h115;
  localparam logic [11:0] ref_offset    = 12'h116;
  localparam int          addr_width    = 12;
  localparam int          data_width    = 8;

  // ***********************************************
  // Field positions and reset values
  // ***********************************************
  localparam int formula_lsb  = 4;
  localparam int halt_bit     = 3;
  localparam int wrap_bit     = 7;
  localparam int above_bit    = 6;
  localparam int below_bit    = 5;
  localparam int updated_bit  = 4;
  localparam int lower_ref_bit = 4;
  localparam logic [7:0] reg_reset_value = 8'h00;

  // ***********************************************
  // Encodings
  // ***********************************************
  localparam logic [2:0] error_formula_select_delta      = 3'h0;
  localparam logic [2:0] error_formula_select_setpoint   = 3'h1;
  localparam logic [2:0] error_formula_select_filter     = 3'h2;
  localparam logic [2:0] error_formula_select_prev_filt  = 3'h4;
  localparam logic [2:0] error_formula_select_filt_setpt = 3'h5;

  localparam logic [2:0] thr_never      = 3'h0;
  localparam logic [2:0] thr_below      = 3'h1;
  localparam logic [2:0] thr_not_below  = 3'h2;
  localparam logic [2:0] thr_inside     = 3'h3;
  localparam logic [2:0] thr_outside    = 3'h4;
  localparam logic [2:0] thr_not_above  = 3'h5;
  localparam logic [2:0] thr_above      = 3'h6;
  localparam logic [2:0] thr_always     = 3'h7;

  localparam logic [1:0] upper_ref_supply   = 2'h0;
  localparam logic [1:0] upper_ref_external = 2'h2;
  localparam logic [1:0] upper_ref_fixed    = 2'h3;

  // Stage codes reported in the status low field
  localparam logic [2:0] stage_idle   = 3'h0;
  localparam logic [2:0] stage_pre1   = 3'h1;
  localparam logic [2:0] stage_acq1   = 3'h2;
  localparam logic [2:0] stage_conv1  = 3'h3;
  localparam logic [2:0] stage_unused = 3'h4;
  localparam logic [2:0] stage_pre2   = 3'h5;
  localparam logic [2:0] stage_acq2   = 3'h6;
  localparam logic [2:0] stage_conv2  = 3'h7;

  // Data from the surrounding converter
  typedef struct packed {
    logic [15:0] result;
    logic [15:0] setpoint;
    logic [15:0] filtered;
    logic [15:0] upper;
    logic [15:0] lower;
  } compute_data_type;

  // Software register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  // Reference routing outputs
  typedef struct packed {
    logic       lower_external;
    logic [1:0] upper_source;
  } ref_route_type;

endpackage

// *** design/adc_error_threshold_status.sv ***
// Purpose: Deviation computation, threshold test and status for the converter
// Assumes: Sequencer supplies stage strobes; conversion data are signed 16 bit
// Notes:   One clock, synchronous active-high reset, plain register port
//          Stage code is trusted only when the sequencer shares this clock
//
// Operation
// - Formula select in control bits 6:4
// - Code 000: result minus previous
// - Code 001: deviation against setpoint
// - Code 010: deviation against filtered value
// - Code 100: previous minus filtered
// - Code 101: filtered minus setpoint
// - Double-sample difference equals second minus first
// - Halt run bit on threshold hit
// - Without halt, software stops retriggering
// - Select 111 always, 000 never interrupts
// - 110 above upper, 101 not above
// - 100 outside limits, 011 inside
// - 010 not below, 001 below lower
// - Wrap flag shows accumulator or deviation overflow
// - Above-upper flag in status bit 6
// - Below-lower flag in status bit 5
// - Updated flag set on computation updates
// - Stage code reports converter cycle phase
// - Lower reference select routes negative reference
// - Upper reference select chooses positive source
// - Double-sample makes two conversions per trigger
// - Repeat-trigger retriggers run bit after completion
// - Previous register loaded at conversion start
`timescale 1ns/1ns

module adc_error_threshold_status
  import adc_compute_pkg::*;
#(
  parameter int data_bits = 16
)
(
  input  wire logic                              sys_clk_i,
  input  wire logic                              reset_i,
  input  wire adc_compute_pkg::reg_req_type      reg_req_i,
  output logic [7:0]                             reg_rdata_o,
  input  wire adc_compute_pkg::compute_data_type data_i,
  input  wire logic                              double_sample_enable_i,
  input  wire logic                              previous_source_select_i,
  input  wire logic                              repeat_trigger_i,
  input  wire logic                              run_set_i,
  input  wire logic                              run_clear_i,
  input  wire logic                              conv_start_i,
  input  wire logic                              conv_done_i,
  input  wire logic                              trigger_done_i,
  input  wire logic                              acc_overflow_i,
  input  wire logic                              acc_update_i,
  input  wire logic [2:0]                        stage_i,
  output logic                                   run_o,
  output logic                                   threshold_irq_o,
  output logic [15:0]                            deviation_o,
  output logic [15:0]                            previous_result_o,
  output adc_compute_pkg::ref_route_type         ref_route_o
);

  // Arithmetic is fixed at 16 bits; data_bits must be 16
  if (data_bits != 16)
  begin : g_bad_width
    $error("adc_error_threshold_status: data_bits must be 16");
  end

  // Read-back views assume a byte-wide register port
  if (data_width != 8)
  begin : g_bad_port
    $error("adc_error_threshold_status: register port must be 8 bits");
  end

  // ***********************************************
  // Registers
  // ***********************************************
  logic [2:0]  error_formula_select_reg;
  logic        halt_on_interrupt_reg;
  logic [2:0]  threshold_irq_select_reg;
  logic        lower_reference_select_reg;
  logic [1:0]  upper_reference_select_reg;
  logic        deviation_wrap_reg;
  logic        above_upper_flag_reg;
  logic        below_lower_flag_reg;
  logic        computation_updated_flag_reg;
  logic [2:0]  stage_reg;
  logic [15:0] previous_result_reg;
  logic        second_pending_reg;
  logic        run_reg;
  logic        irq_reg;
  logic [15:0] deviation_reg;
  logic [7:0]  rdata_reg;

  logic signed [15:0] deviation_next;
  logic               deviation_wrap_next;
  logic               above_next;
  logic               below_next;
  logic               irq_hit;
  logic               ctrl3_wr;
  logic               status_wr;
  logic               ref_wr;
  logic               compute_strobe;

  assign ctrl3_wr  = reg_req_i.wr && (reg_req_i.addr == ctrl3_offset);
  assign status_wr = reg_req_i.wr && (reg_req_i.addr == status_offset);
  assign ref_wr    = reg_req_i.wr && (reg_req_i.addr == ref_offset);

  // Computation happens once the last conversion of a trigger is finished
  assign compute_strobe = conv_done_i && !(double_sample_enable_i && !second_pending_reg);

  // ***********************************************
  // Control register: formula, halt, threshold mode
  // ***********************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      error_formula_select_reg <= reg_reset_value[2:0];
      halt_on_interrupt_reg    <= 1'b0;
      threshold_irq_select_reg <= reg_reset_value[2:0];
    end
    else if (ctrl3_wr)
    begin
      error_formula_select_reg <= reg_req_i.wdata[formula_lsb +: 3];
      halt_on_interrupt_reg    <= reg_req_i.wdata[halt_bit];
      threshold_irq_select_reg <= reg_req_i.wdata[2:0];
    end
  end

  // ***********************************************
  // Reference select register
  // ***********************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      lower_reference_select_reg <= 1'b0;
      upper_reference_select_reg <= upper_ref_supply;
    end
    else if (ref_wr)
    begin
      lower_reference_select_reg <= reg_req_i.wdata[lower_ref_bit];
      upper_reference_select_reg <= reg_req_i.wdata[1:0];
    end
  end

  // Routing follows the register; reserved 01 is passed through untouched
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      ref_route_o <= '0;
    else
    begin
      ref_route_o.lower_external <= lower_reference_select_reg;
      ref_route_o.upper_source   <= upper_reference_select_reg;
    end
  end

  // ***********************************************
  // Previous register and double-sample tracking
  // ***********************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      previous_result_reg <= '0;
      second_pending_reg  <= 1'b0;
    end
    else
    begin
      if (conv_start_i)
      begin
        // Copy made before the new result lands
        previous_result_reg <= previous_source_select_i ? data_i.filtered
                                                        : data_i.result;
      end
      // A filtered copy made at start gives way to the first sample
      if (conv_done_i && double_sample_enable_i)
      begin
        second_pending_reg <= !second_pending_reg;
        if (!second_pending_reg)
        begin
          // First conversion's data become the previous value
          previous_result_reg <= data_i.result;
        end
      end
      else if (!double_sample_enable_i)
        second_pending_reg <= 1'b0;
    end
  end

  // ***********************************************
  // Deviation formula
  // ***********************************************
  // Two guard bits keep each difference exact before the range test
  always_comb
  begin
    logic signed [17:0] wide;
    logic signed [17:0] res;
    logic signed [17:0] prv;
    logic signed [17:0] stp;
    logic signed [17:0] flt;
    wide = '0;
    res = 18'(signed'(data_i.result));
    prv = 18'(signed'(previous_result_reg));
    stp = 18'(signed'(data_i.setpoint));
    flt = 18'(signed'(data_i.filtered));
    case (error_formula_select_reg)
      error_formula_select_delta:
        wide = res - prv;
      error_formula_select_setpoint:
        wide = double_sample_enable_i ? (res - prv) - stp : res - stp;
      error_formula_select_filter:
        wide = double_sample_enable_i ? (res - prv) - flt : res - flt;
      error_formula_select_prev_filt:
        wide = prv - flt;
      error_formula_select_filt_setpt:
        wide = flt - stp;
      default:
        wide = '0; // Reserved codes give zero
    endcase
    deviation_next      = wide[15:0];
    // Overflow when the result does not fit 16 signed bits
    deviation_wrap_next = (wide[17:15] != {3{wide[15]}});
  end

  // ***********************************************
  // Threshold tests
  // ***********************************************
  // Inside excludes both limits, so equality never counts
  always_comb
  begin
    logic signed [15:0] dev;
    dev        = deviation_next[15:0];
    above_next = dev > signed'(data_i.upper);
    below_next = dev < signed'(data_i.lower);
    case (threshold_irq_select_reg)
      thr_never:     irq_hit = 1'b0;
      thr_below:     irq_hit = below_next;
      thr_not_below: irq_hit = !below_next;
      thr_inside:    irq_hit = !below_next && !above_next &&
                               (dev != signed'(data_i.lower)) &&
                               (dev != signed'(data_i.upper));
      thr_outside:   irq_hit = below_next || above_next;
      thr_not_above: irq_hit = !above_next;
      thr_above:     irq_hit = above_next;
      thr_always:    irq_hit = 1'b1;
      default:       irq_hit = 1'b0;
    endcase
  end

  // ***********************************************
  // Computation results and flags
  // ***********************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      deviation_reg        <= '0;
      deviation_wrap_reg   <= 1'b0;
      above_upper_flag_reg <= 1'b0;
      below_lower_flag_reg <= 1'b0;
      irq_reg              <= 1'b0;
    end
    else
    begin
      irq_reg <= compute_strobe && irq_hit; // One-cycle event
      if (compute_strobe)
      begin
        deviation_reg        <= deviation_next[15:0];
        deviation_wrap_reg   <= deviation_wrap_next;
        above_upper_flag_reg <= above_next;
        below_lower_flag_reg <= below_next;
      end
    end
  end

  // ***********************************************
  // Status flags and stage code
  // ***********************************************
  // Updated flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      computation_updated_flag_reg <= 1'b0;
    else if (compute_strobe || acc_update_i)
      computation_updated_flag_reg <= 1'b1;
    else if (status_wr && !reg_req_i.wdata[updated_bit])
      computation_updated_flag_reg <= 1'b0;
  end

  // Stage code; unused 100 is mapped to idle
  // Sequencer shares this clock; a faster converter clock needs a synchroniser
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      stage_reg <= stage_idle;
    else if (stage_i == stage_unused)
      stage_reg <= stage_idle;
    else
      stage_reg <= stage_i;
  end

  // ***********************************************
  // Run bit control
  // ***********************************************
  // Halt needs the closing trigger and the computation in one cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      run_reg <= 1'b0;
    else if (run_clear_i)
      run_reg <= 1'b0;
    else if (run_set_i)
      run_reg <= 1'b1;
    else if (trigger_done_i && run_reg)
    begin
      if (!repeat_trigger_i)
        run_reg <= 1'b0;
      else if (halt_on_interrupt_reg && compute_strobe && irq_hit)
        run_reg <= 1'b0;
      else
        run_reg <= 1'b1;
    end
  end

  // ***********************************************
  // Read-back views of the three registers
  // ***********************************************
  logic [7:0] ctrl3_view;
  logic [7:0] status_view;
  logic [7:0] ref_view;

  // Bit 7 of the control register is unimplemented
  assign ctrl3_view  = {1'b0, error_formula_select_reg, halt_on_interrupt_reg,
                        threshold_irq_select_reg};
  // Wrap flag also shows a live accumulator overflow
  assign status_view = {deviation_wrap_reg | acc_overflow_i, above_upper_flag_reg,
                        below_lower_flag_reg, computation_updated_flag_reg, 1'b0,
                        stage_reg};
  assign ref_view    = {3'h0, lower_reference_select_reg, 2'h0,
                        upper_reference_select_reg};

  // ***********************************************
  // Read port: data in the cycle after the strobe
  // ***********************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      rdata_reg <= reg_reset_value;
    else if (reg_req_i.rd)
    begin
      case (reg_req_i.addr)
        ctrl3_offset:
          rdata_reg <= ctrl3_view;
        status_offset:
          rdata_reg <= status_view;
        ref_offset:
          rdata_reg <= ref_view;
        default:
          rdata_reg <= 8'h00; // Unmapped reads zero
      endcase
    end
    else
      rdata_reg <= 8'h00;
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o       = rdata_reg;
  assign run_o             = run_reg;
  assign threshold_irq_o   = irq_reg;
  assign deviation_o       = deviation_reg;
  assign previous_result_o = previous_result_reg;

endmodule // adc_error_threshold_status

// *** sim/adc_error_threshold_status_checker.sv ***
// Purpose: Port-level temporal checks for the computation block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Attached to every instance by the bind at the foot
`timescale 1ns/1ns
module adc_error_threshold_status_checker
  import adc_compute_pkg::*;
#(
  parameter int data_bits = 16
)
(
  input wire logic                              sys_clk_i,
  input wire logic                              reset_i,
  input wire adc_compute_pkg::reg_req_type      reg_req_i,
  input wire logic [7:0]                        reg_rdata_o,
  input wire adc_compute_pkg::compute_data_type data_i,
  input wire logic                              double_sample_enable_i,
  input wire logic                              previous_source_select_i,
  input wire logic                              repeat_trigger_i,
  input wire logic                              run_set_i,
  input wire logic                              run_clear_i,
  input wire logic                              conv_start_i,
  input wire logic                              conv_done_i,
  input wire logic                              trigger_done_i,
  input wire logic                              run_o,
  input wire logic                              threshold_irq_o,
  input wire logic [15:0]                       deviation_o,
  input wire logic [15:0]                       previous_result_o,
  input wire adc_compute_pkg::ref_route_type    ref_route_o
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_rd(logic [11:0] a);
    reg_req_i.rd && reg_req_i.addr == a;
  endsequence
  // Routing lags the register by one cycle
  sequence s_ref_wr;
    reg_req_i.wr && reg_req_i.addr == ref_offset;
  endsequence
  property p_idle_rdata;
    !$past(reg_req_i.rd) |-> reg_rdata_o == 8'h00;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read slot");
  property p_ctrl_top;
    s_rd(ctrl3_offset) |=> reg_rdata_o[7] == 1'b0;
  endproperty
  a_ctrl_top: assert property (p_ctrl_top) else $error("control bit 7 not zero");
  property p_status_gap;
    s_rd(status_offset) |=> reg_rdata_o[3] == 1'b0;
  endproperty
  a_status_gap: assert property (p_status_gap) else $error("status bit 3 not zero");
  property p_ref_route;
    s_ref_wr |=> ##1 ref_route_o == {$past(reg_req_i.wdata[4], 2), $past(reg_req_i.wdata[1:0], 2)};
  endproperty
  a_ref_route: assert property (p_ref_route) else $error("reference route mismatch");
  property p_irq_cause;
    threshold_irq_o |-> $past(conv_done_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without computation");
  property p_dev_hold;
    !$past(conv_done_i) |-> $stable(deviation_o);
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("deviation moved without result");
  property p_prev_load;
    conv_start_i && !double_sample_enable_i |=> previous_result_o ==
      ($past(previous_source_select_i) ? $past(data_i.filtered) : $past(data_i.result));
  endproperty
  a_prev_load: assert property (p_prev_load) else $error("previous value not loaded");
  property p_run_fall;
    $fell(run_o) |-> $past(run_clear_i) || $past(trigger_done_i);
  endproperty
  a_run_fall: assert property (p_run_fall) else $error("run bit dropped unprompted");
  property p_run_single;
    run_o && !repeat_trigger_i && trigger_done_i && !run_set_i |=> !run_o;
  endproperty
  a_run_single: assert property (p_run_single) else $error("run bit kept after trigger");
endmodule // adc_error_threshold_status_checker

bind adc_error_threshold_status adc_error_threshold_status_checker #(.data_bits(data_bits)) i_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .data_i(data_i), .double_sample_enable_i(double_sample_enable_i),
  .previous_source_select_i(previous_source_select_i), .repeat_trigger_i(repeat_trigger_i),
  .run_set_i(run_set_i), .run_clear_i(run_clear_i), .conv_start_i(conv_start_i),
  .conv_done_i(conv_done_i), .trigger_done_i(trigger_done_i), .run_o(run_o),
  .threshold_irq_o(threshold_irq_o), .deviation_o(deviation_o),
  .previous_result_o(previous_result_o), .ref_route_o(ref_route_o));

// *** sim/adc_error_threshold_status_tb.sv ***
// Purpose: Self-checking bench for the computation block
// Assumes: 100 MHz clock, reset held for 16 cycles
// Notes:   All inputs move on rising edges by non-blocking assignment
`timescale 1ns/1ns
module adc_error_threshold_status_tb;
  import adc_compute_pkg::*;
  localparam logic [5:0] p_set = 6'h20, p_clr = 6'h10, p_start = 6'h08;
  localparam logic [5:0] p_done = 6'h04, p_trig = 6'h02, p_upd = 6'h01;
  localparam logic signed [15:0] up = 16'h0064, lo = 16'hff9c;
  logic               sys_clk_i = 1'b0;
  logic               reset_i = 1'b1;
  reg_req_type        req = '0;
  compute_data_type   cd = '0;
  logic               double_sample_enable = 1'b0, previous_source_select = 1'b0, rpt = 1'b0, ovf = 1'b0;
  logic [5:0]         pl = '0;
  logic [2:0]         stage = '0;
  logic [7:0]         rdata, v;
  logic               run, irq, rd_irq;
  logic [15:0]        dev, prev;
  ref_route_type      route;
  int                 n_fail = 0, compares = 0, cycles = 0;
  logic signed [15:0] dv [5] = '{16'hff38, 16'hff9c, 16'h0000, 16'h0064, 16'h00c8};

  adc_error_threshold_status i_adc_error_threshold_status (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .data_i(cd), .double_sample_enable_i(double_sample_enable), .previous_source_select_i(previous_source_select),
    .repeat_trigger_i(rpt), .run_set_i(pl[5]), .run_clear_i(pl[4]), .conv_start_i(pl[3]),
    .conv_done_i(pl[2]), .trigger_done_i(pl[1]), .acc_update_i(pl[0]),
    .acc_overflow_i(ovf), .stage_i(stage), .run_o(run), .threshold_irq_o(irq),
    .deviation_o(dev), .previous_result_o(prev), .ref_route_o(route));

  // ********************
  // Clock, watchdog, helpers
  // ********************
  always #5 sys_clk_i = ~sys_clk_i;
  // A hang ends the run as a mismatch
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic s, input logic e);
    check({15'h0000, s}, {15'h0000, e});
  endtask
  task automatic cyc();
    @(posedge sys_clk_i);
    #1;
  endtask
  // Strobes last one cycle; sampling waits past the edge
  task automatic wr(input logic [11:0] a, input logic [7:0] w);
    @(posedge sys_clk_i);
    req <= '{a, w, 1'b1, 1'b0};
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk_i);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge sys_clk_i);
    pl <= m;
    @(posedge sys_clk_i);
    pl <= '0;
    #1;
  endtask
  // Previous loads at start, then the result arrives
  task automatic error_formula_select(input logic [2:0] f, t, input logic [15:0] a, b);
    wr(ctrl3_offset, {1'b0, f, 1'b0, t});
    @(posedge sys_clk_i);
    cd.result <= a;
    pulse(p_start);
    @(posedge sys_clk_i);
    cd.result <= b;
    pulse(p_done);
    rd_irq = irq;
  endtask
  function automatic logic [15:0] expdev(input logic [2:0] f, input logic [15:0] a, b);
    case (f)
      3'h0: return b - a;
      3'h1: return b - cd.setpoint;
      3'h2: return b - cd.filtered;
      3'h4: return a - cd.filtered;
      3'h5: return cd.filtered - cd.setpoint;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic expirq(input logic [2:0] t, input logic signed [15:0] x);
    case (t)
      3'h1: return x < lo;
      3'h2: return x >= lo;
      3'h3: return x > lo && x < up;
      3'h4: return x < lo || x > up;
      3'h5: return x <= up;
      3'h6: return x > up;
      3'h7: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd(ctrl3_offset + 12'(i));
      check({8'h00, v}, 16'h0000);
    end
    wr(ctrl3_offset, 8'hff);
    rd(ctrl3_offset);
    check({8'h00, v}, 16'h007f);
    wr(status_offset, 8'hff);
    rd(status_offset);
    check({8'h00, v}, 16'h0000);
    wr(ref_offset, 8'hff);
    rd(ref_offset);
    check({8'h00, v}, 16'h0013);
    for (int i = 0; i < 4; i++)
    begin
      wr(ref_offset, {3'h0, i[0], 2'h0, i[1:0]});
      cyc();
      check({13'h0000, route}, {13'h0000, i[0], i[1:0]});
    end
    @(posedge sys_clk_i);
    cd <= '{16'h0000, 16'h0040, 16'h0010, up, lo};
    for (int f = 0; f < 8; f++)
    begin
      error_formula_select(3'(f), 3'h7, 16'h0100, 16'h0250);
      check(dev, expdev(3'(f), 16'h0100, 16'h0250));
      chk1(rd_irq, 1'b1);
      check(prev, 16'h0100);
    end
    @(posedge sys_clk_i);
    cd.setpoint <= 16'h0000;
    for (int t = 0; t < 8; t++)
      for (int i = 0; i < 5; i++)
      begin
        error_formula_select(3'h1, 3'(t), 16'h0000, dv[i]);
        chk1(rd_irq, expirq(3'(t), dv[i]));
        rd(status_offset);
        check({14'h0000, v[6:5]}, {14'h0000, dv[i] > up, dv[i] < lo});
      end
    // Two samples per trigger: second minus first, then setpoint
    @(posedge sys_clk_i);
    double_sample_enable <= 1'b1;
    cd.setpoint <= 16'h0005;
    error_formula_select(3'h1, 3'h0, 16'h000a, 16'h000a);
    @(posedge sys_clk_i);
    cd.result <= 16'h001e;
    pulse(p_done);
    check(dev, 16'h000f);
    check(prev, 16'h000a);
    @(posedge sys_clk_i);
    double_sample_enable <= 1'b0;
    previous_source_select <= 1'b1;
    cd.filtered <= 16'h0033;
    pulse(p_start);
    check(prev, 16'h0033);
    @(posedge sys_clk_i);
    rpt <= 1'b1;
    previous_source_select <= 1'b0;
    wr(ctrl3_offset, 8'h0f);
    pulse(p_set);
    chk1(run, 1'b1);
    pulse(p_done | p_trig);
    cyc();
    chk1(run, 1'b0);
    wr(ctrl3_offset, 8'h08);
    pulse(p_set);
    pulse(p_done | p_trig);
    chk1(run, 1'b1);
    wr(ctrl3_offset, 8'h07);
    pulse(p_set);
    pulse(p_done | p_trig);
    cyc();
    chk1(run, 1'b1);
    pulse(p_clr);
    chk1(run, 1'b0);
    @(posedge sys_clk_i);
    rpt <= 1'b0;
    pulse(p_set);
    pulse(p_trig);
    chk1(run, 1'b0);
    @(posedge sys_clk_i);
    ovf <= 1'b1;
    rd(status_offset);
    chk1(v[7], 1'b1);
    @(posedge sys_clk_i);
    ovf <= 1'b0;
    rd(status_offset);
    chk1(v[7], 1'b0);
    @(posedge sys_clk_i);
    cd.setpoint <= 16'h8000;
    error_formula_select(3'h1, 3'h0, 16'h7fff, 16'h7fff);
    rd(status_offset);
    chk1(v[7], 1'b1);
    wr(status_offset, 8'h00);
    rd(status_offset);
    chk1(v[4], 1'b0);
    pulse(p_upd);
    rd(status_offset);
    chk1(v[4], 1'b1);
    for (int s = 0; s < 8; s++)
    begin
      @(posedge sys_clk_i);
      stage <= 3'(s); // Sequencer on this clock
      rd(status_offset);
      check({13'h0000, v[2:0]}, (s == 4) ? 16'h0000 : 16'(s));
    end
    close_out();
  end
endmodule // adc_error_threshold_status_tb
